// ==== shared/fl_pkg.sv ====
`default_nettype none
package fl_pkg;
   // ************************************
   // addresses on the host port
   // ************************************
   localparam logic [15:0] buf_ctrl_base   = 16'h1000;
   localparam logic [15:0] head0_off       = 16'h0000;
   localparam logic [15:0] head1_off       = 16'h0003;
   localparam logic [15:0] count_off       = 16'h0006;
   localparam logic [15:0] clear_ptr_off   = 16'h0009;
   localparam logic [15:0] count_mid_addr  = 16'h0c52;
   localparam logic [15:0] count_high_addr = 16'h0c53;
   localparam logic [15:0] count_top_addr  = 16'h0c51;
   // ************************************
   // field layout and initial values
   // ************************************
   localparam int          id_w            = 19;
   localparam int          addr_w          = 21;
   localparam int          byte_addr_w     = 30;
   localparam logic [18:0] head0_init      = 19'h00080;
   localparam logic [18:0] head1_init_16m  = 19'h00082;
   localparam logic [18:0] head1_init_64m  = 19'h00083;
   localparam logic [18:0] private_last    = 19'h0007f;
   localparam int          buffer_bytes    = 1536;
   localparam int          sram_words_per  = 3;
   localparam int          page_shift_16m  = 11;
   localparam int          page_shift_64m  = 12;
   localparam int          top_bit_pos     = 7;
   // ************************************
   // types
   // ************************************
   typedef enum logic {mem_16m, mem_64m} mem_type_type;

   typedef struct packed {
      logic [18:0] head0;
      logic [18:0] head1;
      logic [18:0] count;
      logic [7:0]  rdata;
      logic        rd_hit;
      logic        link_valid;
      logic        link_bank;
      logic [20:0] link_addr;
      logic [18:0] link_next;
   } regs_type;

   typedef struct packed {
      logic [18:0] snap;
   } snap_state_type;
endpackage
`default_nettype wire

// ==== shared/snap_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface snap_if;
   logic        capture;
   logic [18:0] count;
   logic [18:0] snap;
   modport owner  (output capture, output count, input snap);
   modport keeper (input capture, input count, output snap);
endinterface
`default_nettype wire

// ==== sim/free_list_regs_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module free_list_regs_tb_top;
   logic        clk;
   logic        rst_n;
   logic [15:0] host_addr;
   logic        host_rd;
   logic        host_wr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        oe;
   logic        mem_type;
   logic        blk_take;
   logic        blk_give;
   logic        rel_valid;
   logic [18:0] rel_id;
   logic        lk_valid;
   logic        lk_bank;
   logic [20:0] lk_addr;
   logic [18:0] lk_next;
   logic [18:0] head0;
   logic [18:0] head1;
   logic [18:0] count;
   int          mismatches;
   int          tests_run;
   logic [18:0] h [2];
   logic [18:0] cnt;
   logic [18:0] id;
   logic [7:0]  d;
   logic        ok;
   logic        b;

   free_list_regs dut_u (.clk(clk), .rst_n(rst_n), .host_addr(host_addr), .host_rd(host_rd),
      .host_wr(host_wr), .host_data_bus_i(wdata), .host_data_bus_o(rdata),
      .host_data_bus_oe(oe), .memory_type_setting(mem_type), .blk_take(blk_take),
      .blk_give(blk_give), .rel_valid(rel_valid), .rel_id(rel_id), .link_wr_valid(lk_valid),
      .link_wr_bank(lk_bank), .link_wr_addr(lk_addr), .link_wr_next(lk_next),
      .bank0_free_list_head(head0), .bank1_free_list_head(head1), .free_block_count(count));

   host_model host_u (.clk(clk), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
      .host_data_bus_i(wdata), .host_data_bus_o(rdata), .host_data_bus_oe(oe));

   // ************************************
   // helpers
   // ************************************
   task automatic check(input logic [20:0] seen, input logic [20:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (mismatches == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // bank of the page where the buffer starts
   function automatic logic bank_of(input logic [18:0] i, input logic t);
      logic [29:0] p;
      p = {11'h000, i} * 30'h0000600;
      return t ? p[12] : p[11];
   endfunction

   task automatic pulse(input logic tk, input logic gv);
      @(negedge clk);
      blk_take = tk;
      blk_give = gv;
      @(negedge clk);
      blk_take = 1'b0;
      blk_give = 1'b0;
   endtask

   task automatic check_heads();
      logic [18:0] e;
      for (int k = 0; k < 6; k++) begin
         e = (k < 3) ? h[0] : h[1];
         host_u.read_byte(16'h1000 + 16'(k), d, ok);
         check(d, 8'(e >> (8 * (k % 3))));
         check(ok, 1'b1);
      end
      check(head0, h[0]);
      check(head1, h[1]);
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end

   // ************************************
   // main sequence
   // ************************************
   initial begin
      rst_n = 1'b0;
      mem_type = 1'b0;
      blk_take = 1'b0;
      blk_give = 1'b0;
      rel_valid = 1'b0;
      rel_id = 19'h00000;
      mismatches = 0;
      tests_run = 0;
      void'($urandom(32'h13c3));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      check(count, 19'h00000);
      for (int t = 0; t < 2; t++) begin
         mem_type = t[0];
         host_u.clear_heads(8'($urandom));
         h[0] = 19'h00080;
         h[1] = t ? 19'h00083 : 19'h00082;
         host_u.write_byte(16'h1000, 8'h55);
         host_u.write_byte(16'h1004, 8'h2a);
         check_heads();
         // releases back to back, corners first
         rel_valid = 1'b1;
         for (int i = 0; i < 30; i++) begin
            id = (i == 0) ? 19'd130 : (i == 1) ? 19'd131 : 19'($urandom);
            rel_id = id;
            b = bank_of(id, t[0]);
            @(negedge clk);
            check(lk_valid, 1'b1);
            check(lk_bank, b);
            check(lk_addr, {2'b00, id} * 21'h00003);
            check(lk_next, h[b]);
            h[b] = id;
         end
         rel_valid = 1'b0;
         @(negedge clk);
         check(lk_valid, 1'b0);
         check_heads();
      end
      for (int n = 0; n < 2; n++) begin
         // second pass sets the top bit, else the last readback byte is always zero
         cnt = n ? (19'($urandom) | 19'h40000) : (19'($urandom) & 19'h3ffff);
         host_u.write_count(cnt);
         check(count, cnt);
         host_u.read_byte(16'h1006, d, ok);
         check(d, cnt[7:0]);
         check(ok, 1'b1);
         pulse(1'b0, 1'b1);
         host_u.read_byte(16'h0c52, d, ok);
         check(d, cnt[15:8]);
         pulse(1'b1, 1'b1);
         host_u.read_byte(16'h0c53, d, ok);
         check(d, {6'h00, cnt[17:16]});
         pulse(1'b0, 1'b1);
         host_u.read_byte(16'h0c51, d, ok);
         check(d, {cnt[18], 7'h00});
         // take alone: the count must step down too
         pulse(1'b1, 1'b0);
         cnt = cnt + 19'h00001;
         check(count, cnt);
         host_u.read_byte(16'h1006, d, ok);
         check(d, cnt[7:0]);
         host_u.read_byte(16'h0c52, d, ok);
         check(d, cnt[15:8]);
      end
      // unmapped place answers nothing
      host_u.read_byte(16'h1010, d, ok);
      check({ok, d}, 9'h000);
      report_and_stop();
   end
endmodule
`default_nettype wire

// ==== sim/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ************************************
// host processor on the byte-wide register port
// ************************************
module host_model (
   // clock
   input  wire logic        clk,
   // register port toward the device
   output logic      [15:0] host_addr,
   output logic             host_rd,
   output logic             host_wr,
   output logic      [7:0]  host_data_bus_i,
   // answer from the device
   input  wire logic [7:0]  host_data_bus_o,
   input  wire logic        host_data_bus_oe
);
   initial begin
      host_addr = 16'h0000;
      host_rd = 1'b0;
      host_wr = 1'b0;
      host_data_bus_i = 8'h00;
   end

   task automatic write_byte(input logic [15:0] a, input logic [7:0] v);
      @(negedge clk);
      host_addr = a;
      host_data_bus_i = v;
      host_wr = 1'b1;
      @(negedge clk);
      host_wr = 1'b0;
      // released data never shows the last value
      host_data_bus_i = ~v;
   endtask

   // answer stands one cycle, taken before the strobe drops
   task automatic read_byte(input logic [15:0] a, output logic [7:0] v, output logic ok);
      @(negedge clk);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge clk);
      v = host_data_bus_o;
      ok = host_data_bus_oe;
      host_rd = 1'b0;
   endtask

   // caller keeps the count within memory size over 1.5 KB
   task automatic write_count(input logic [18:0] c);
      write_byte(16'h1006, c[7:0]);
      write_byte(16'h1007, c[15:8]);
      write_byte(16'h1008, {5'h00, c[18:16]});
   endtask

   // command only after the memory type is settled
   task automatic clear_heads(input logic [7:0] v);
      write_byte(16'h1009, v);
   endtask
endmodule
`default_nettype wire

// ==== verilog/count_snapshot.sv ====
`timescale 1ns/100ps
`default_nettype none
module count_snapshot (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // snapshot carrier
   snap_if.keeper    sif
);
   fl_pkg::snap_state_type s_q;
   fl_pkg::snap_state_type s_d;

   always_comb begin
      s_d = s_q;
      // only the low-byte read refreshes the copy
      if (sif.capture) begin
         s_d.snap = sif.count;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sif.snap = s_q.snap;
endmodule
`default_nettype wire

// ==== verilog/free_list_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module free_list_regs (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // host register port
   input  wire logic [15:0] host_addr,
   input  wire logic        host_rd,
   input  wire logic        host_wr,
   input  wire logic [7:0]  host_data_bus_i,
   output logic      [7:0]  host_data_bus_o,
   output logic             host_data_bus_oe,
   // configuration from the memory controller
   input  wire logic        memory_type_setting,
   // block accounting from the buffer machinery
   input  wire logic        blk_take,
   input  wire logic        blk_give,
   // buffer release from output port logic
   input  wire logic        rel_valid,
   input  wire logic [18:0] rel_id,
   // link write toward the buffer memory
   output logic             link_wr_valid,
   output logic             link_wr_bank,
   output logic      [20:0] link_wr_addr,
   output logic      [18:0] link_wr_next,
   // current state
   output logic      [18:0] bank0_free_list_head,
   output logic      [18:0] bank1_free_list_head,
   output logic      [18:0] free_block_count
);
   // ************************************
   // helpers
   // ************************************
   // bank of the page where a buffer starts
   function automatic logic start_bank(input logic [18:0] id, input logic big);
      logic [29:0] byte_addr;
      byte_addr = 30'(id) * 30'(fl_pkg::buffer_bytes);
      start_bank = big ? byte_addr[fl_pkg::page_shift_64m]
                       : byte_addr[fl_pkg::page_shift_16m];
   endfunction

   function automatic logic [20:0] sram_loc(input logic [18:0] id);
      sram_loc = 21'(id) * 21'(fl_pkg::sram_words_per);
   endfunction

   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a == (fl_pkg::buf_ctrl_base + off));
   endfunction

   // ************************************
   // decode
   // ************************************
   logic        big;
   logic        wr_clear;
   logic        rd_low;
   logic        rel_bank;
   fl_pkg::regs_type r_q;
   fl_pkg::regs_type r_d;
   snap_if      sif ();

   assign big      = (memory_type_setting == fl_pkg::mem_64m);
   assign wr_clear = host_wr && hit(host_addr, fl_pkg::clear_ptr_off);
   assign rd_low   = host_rd && hit(host_addr, fl_pkg::count_off);
   assign rel_bank = start_bank(rel_id, big);

   assign sif.capture = rd_low;
   assign sif.count   = r_q.count;

   count_snapshot u_snap (
      .clk   (clk),
      .rst_n (rst_n),
      .sif   (sif)
   );

   // ************************************
   // next state
   // ************************************
   always_comb begin
      r_d = r_q;
      r_d.link_valid = 1'b0;
      r_d.rd_hit     = 1'b0;
      r_d.rdata      = 8'h00;
      // heads move only by the clear write or a release, never by a host write to their own bytes
      if (wr_clear) begin
         r_d.head0 = fl_pkg::head0_init;
         r_d.head1 = big ? fl_pkg::head1_init_64m : fl_pkg::head1_init_16m;
      end else if (rel_valid) begin
         // push onto the list of the bank it really starts in
         r_d.link_valid = 1'b1;
         r_d.link_bank  = rel_bank;
         r_d.link_addr  = sram_loc(rel_id);
         r_d.link_next  = rel_bank ? r_q.head1 : r_q.head0;
         if (rel_bank) begin
            r_d.head1 = rel_id;
         end else begin
            r_d.head0 = rel_id;
         end
      end
      // count: host byte write wins over accounting
      if (host_wr && hit(host_addr, fl_pkg::count_off)) begin
         r_d.count[7:0] = host_data_bus_i;
      end else if (host_wr && hit(host_addr, fl_pkg::count_off + 16'h0001)) begin
         r_d.count[15:8] = host_data_bus_i;
      end else if (host_wr && hit(host_addr, fl_pkg::count_off + 16'h0002)) begin
         r_d.count[18:16] = host_data_bus_i[2:0];
      end else if (blk_take && !blk_give) begin
         r_d.count = r_q.count - 19'h00001;
      end else if (blk_give && !blk_take) begin
         r_d.count = r_q.count + 19'h00001;
      end
      // read path
      if (host_rd) begin
         r_d.rd_hit = 1'b1;
         unique case (host_addr)
            fl_pkg::buf_ctrl_base + fl_pkg::head0_off:
               r_d.rdata = r_q.head0[7:0];
            fl_pkg::buf_ctrl_base + fl_pkg::head0_off + 16'h0001:
               r_d.rdata = r_q.head0[15:8];
            fl_pkg::buf_ctrl_base + fl_pkg::head0_off + 16'h0002:
               r_d.rdata = {5'h00, r_q.head0[18:16]};
            fl_pkg::buf_ctrl_base + fl_pkg::head1_off:
               r_d.rdata = r_q.head1[7:0];
            fl_pkg::buf_ctrl_base + fl_pkg::head1_off + 16'h0001:
               r_d.rdata = r_q.head1[15:8];
            fl_pkg::buf_ctrl_base + fl_pkg::head1_off + 16'h0002:
               r_d.rdata = {5'h00, r_q.head1[18:16]};
            fl_pkg::buf_ctrl_base + fl_pkg::count_off:
               r_d.rdata = r_q.count[7:0];
            fl_pkg::buf_ctrl_base + fl_pkg::count_off + 16'h0001,
            fl_pkg::buf_ctrl_base + fl_pkg::count_off + 16'h0002,
            fl_pkg::buf_ctrl_base + fl_pkg::clear_ptr_off:
               r_d.rdata = 8'h00;
            fl_pkg::count_mid_addr:
               r_d.rdata = sif.snap[15:8];
            fl_pkg::count_high_addr:
               r_d.rdata = {6'h00, sif.snap[17:16]};
            fl_pkg::count_top_addr:
               r_d.rdata = {sif.snap[18], 7'h00};
            default:
               r_d.rd_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // ************************************
   // outputs
   // ************************************
   assign host_data_bus_o      = r_q.rdata;
   assign host_data_bus_oe     = r_q.rd_hit;
   assign link_wr_valid        = r_q.link_valid;
   assign link_wr_bank         = r_q.link_bank;
   assign link_wr_addr         = r_q.link_addr;
   assign link_wr_next         = r_q.link_next;
   assign bank0_free_list_head = r_q.head0;
   assign bank1_free_list_head = r_q.head1;
   assign free_block_count     = r_q.count;

   // ************************************
   // checks
   // ************************************
   property p_head0_init;
      @(posedge clk) disable iff (!rst_n)
      wr_clear |=> (bank0_free_list_head == 19'h00080);
   endproperty
   a_head0_init: assert property (p_head0_init) else $error("bank0 head not 128");

   property p_head0_past_private;
      @(posedge clk) disable iff (!rst_n)
      wr_clear |=> (bank0_free_list_head > fl_pkg::private_last);
   endproperty
   a_head0_past_private: assert property (p_head0_past_private) else $error("head0 in private");

   property p_head1_init;
      @(posedge clk) disable iff (!rst_n)
      wr_clear |=> (bank1_free_list_head == ($past(big) ? 19'h00083 : 19'h00082));
   endproperty
   a_head1_init: assert property (p_head1_init) else $error("bank1 head wrong");

   property p_heads_hold;
      @(posedge clk) disable iff (!rst_n)
      (!wr_clear && !rel_valid) |=> ($stable(bank0_free_list_head) && $stable(bank1_free_list_head));
   endproperty
   a_heads_hold: assert property (p_heads_hold) else $error("head moved without cause");

   property p_release_bank;
      @(posedge clk) disable iff (!rst_n)
      (rel_valid && !wr_clear) |=> link_wr_valid && (link_wr_bank == $past(rel_bank))
         && (link_wr_addr == 21'($past(rel_id)) * 21'h00003)
         && ((link_wr_bank ? bank1_free_list_head : bank0_free_list_head) == $past(rel_id));
   endproperty
   a_release_bank: assert property (p_release_bank) else $error("release misfiled");

   property p_low_read;
      @(posedge clk) disable iff (!rst_n)
      rd_low |=> host_data_bus_oe && (host_data_bus_o == $past(r_q.count[7:0]))
         && (sif.snap == $past(r_q.count));
   endproperty
   a_low_read: assert property (p_low_read) else $error("low read or latch wrong");

   property p_snap_hold;
      @(posedge clk) disable iff (!rst_n)
      !rd_low |=> $stable(sif.snap);
   endproperty
   a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed");

   property p_mid_read;
      @(posedge clk) disable iff (!rst_n)
      (host_rd && host_addr == fl_pkg::count_mid_addr) |=> host_data_bus_o == sif.snap[15:8];
   endproperty
   a_mid_read: assert property (p_mid_read) else $error("mid byte wrong");

   property p_high_read;
      @(posedge clk) disable iff (!rst_n)
      (host_rd && host_addr == fl_pkg::count_high_addr)
         |=> host_data_bus_o == {6'h00, sif.snap[17:16]};
   endproperty
   a_high_read: assert property (p_high_read) else $error("high bits wrong");

   property p_top_read;
      @(posedge clk) disable iff (!rst_n)
      (host_rd && host_addr == fl_pkg::count_top_addr)
         |=> host_data_bus_o == {sif.snap[18], 7'h00};
   endproperty
   a_top_read: assert property (p_top_read) else $error("top bit wrong");
endmodule
`default_nettype wire
